// ---- hdl/jlp_regs.sv ----
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module jlp_regs (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	input  wire logic [9:0]  enc_word_msb,
	input  wire logic [9:0]  enc_word_lsb,
	input  wire logic [3:0]  fast_code,
	input  wire logic [11:0] sample,
	input  wire logic        sample_valid,
	output logic      [7:0]  octet_code,
	output logic      [4:0]  mframe_code,
	output logic      [3:0]  drive_current_code,
	output logic      [5:0]  drive_current_ma,
	output logic      [9:0]  lane_one_word,
	output logic      [9:0]  lane_two_word,
	output logic      [3:0]  detect
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_q;
	logic rst_n_q;

	// Assert at once, release after two edges
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	logic [1:0] gate_q, gate_d;
	logic [7:0] frame_q, frame_d;
	logic [4:0] mframe_q, mframe_d;
	logic [3:0] drive_q, drive_d;
	logic       force1_q, force1_d;
	logic       force2_q, force2_d;
	logic [7:0] l1_hi_q, l1_hi_d;
	logic [1:0] l1_lo_q, l1_lo_d;
	logic [3:0] l2_hi_q, l2_hi_d;
	logic [5:0] l2_lo_q, l2_lo_d;
	logic       fast_en_q, fast_en_d;
	logic       pwr_en_q, pwr_en_d;
	logic [2:0] avg_len_q, avg_len_d;

	always_comb
	begin
		gate_d    = gate_q;
		frame_d   = frame_q;
		mframe_d  = mframe_q;
		drive_d   = drive_q;
		force1_d  = force1_q;
		force2_d  = force2_q;
		l1_hi_d   = l1_hi_q;
		l1_lo_d   = l1_lo_q;
		l2_hi_d   = l2_hi_q;
		l2_lo_d   = l2_lo_q;
		fast_en_d = fast_en_q;
		pwr_en_d  = pwr_en_q;
		avg_len_d = avg_len_q;
		if (wr)
		begin
			case (addr)
				jlp_pkg::OFS_GATE:
				begin
					gate_d[jlp_pkg::GATE_F_BIT] = wdata[jlp_pkg::GATE_F_BIT];
					gate_d[jlp_pkg::GATE_K_BIT] = wdata[jlp_pkg::GATE_K_BIT];
				end
				jlp_pkg::OFS_FRAME:
					frame_d = wdata;
				jlp_pkg::OFS_MFRAME:
					mframe_d = wdata[4:0];
				jlp_pkg::OFS_DRIVE:
					drive_d = wdata[3:0];
				jlp_pkg::OFS_FORCE:
				begin
					force1_d = wdata[jlp_pkg::FORCE1_BIT];
					force2_d = wdata[jlp_pkg::FORCE2_BIT];
				end
				jlp_pkg::OFS_L1_HI:
					l1_hi_d = wdata;
				jlp_pkg::OFS_L1_LO:
					l1_lo_d = wdata[7:6];
				jlp_pkg::OFS_L2_HI:
					l2_hi_d = wdata[7:4];
				jlp_pkg::OFS_L2_LO:
					l2_lo_d = wdata[7:2];
				jlp_pkg::OFS_EST:
				begin
					fast_en_d = wdata[jlp_pkg::FAST_EN_BIT];
					pwr_en_d  = wdata[jlp_pkg::PWR_EN_BIT];
					avg_len_d = wdata[jlp_pkg::AVG_LSB +: 3];
				end
				default:
					gate_d = gate_q;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			gate_q    <= '0;
			frame_q   <= jlp_pkg::RST_FRAME;
			mframe_q  <= '0;
			drive_q   <= '0;
			force1_q  <= 1'b0;
			force2_q  <= 1'b0;
			l1_hi_q   <= '0;
			l1_lo_q   <= '0;
			l2_hi_q   <= '0;
			l2_lo_q   <= '0;
			fast_en_q <= 1'b0;
			pwr_en_q  <= 1'b0;
			avg_len_q <= '0;
		end
		else
		begin
			gate_q    <= gate_d;
			frame_q   <= frame_d;
			mframe_q  <= mframe_d;
			drive_q   <= drive_d;
			force1_q  <= force1_d;
			force2_q  <= force2_d;
			l1_hi_q   <= l1_hi_d;
			l1_lo_q   <= l1_lo_d;
			l2_hi_q   <= l2_hi_d;
			l2_lo_q   <= l2_lo_d;
			fast_en_q <= fast_en_d;
			pwr_en_q  <= pwr_en_d;
			avg_len_q <= avg_len_d;
		end
	end

	// ****************************************
	// Power estimator
	// ****************************************
	jlp_est_if est_bus ();

	assign est_bus.enable       = pwr_en_q;
	assign est_bus.avg_len      = avg_len_q;
	assign est_bus.sample       = sample;
	assign est_bus.sample_valid = sample_valid;

	jlp_power_est u_est (
		.clk   (clk),
		.rst_n (rst_n_q),
		.bus   (est_bus.est)
	);

	// ****************************************
	// Link parameters and outputs
	// ****************************************
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] oct_q, oct_d;
	logic [4:0] mf_q, mf_d;
	logic [3:0] cur_q, cur_d;
	logic [5:0] ma_q, ma_d;
	logic [9:0] l1_q, l1_d;
	logic [9:0] l2_q, l2_d;
	logic [3:0] det_q, det_d;

	always_comb
	begin
		// Frame size only leaves its default when the gate is open
		oct_d = gate_q[jlp_pkg::GATE_F_BIT] ? frame_q : jlp_pkg::RST_FRAME;
		if (gate_q[jlp_pkg::GATE_K_BIT])
			mf_d = mframe_q;
		else if (oct_d == 8'h00)
			mf_d = jlp_pkg::DEF_K_ONE;
		else
			mf_d = jlp_pkg::DEF_K_TWO;
		cur_d = drive_q;
		ma_d  = jlp_pkg::DRV_BASE_MA;
		if (drive_q[3])
			ma_d = ma_d + jlp_pkg::DRV_B3_MA;
		if (drive_q[2])
			ma_d = ma_d - jlp_pkg::DRV_B2_MA;
		if (drive_q[1])
			ma_d = ma_d - jlp_pkg::DRV_B1_MA;
		if (drive_q[0])
			ma_d = ma_d - jlp_pkg::DRV_B0_MA;
		// Forced words bypass the coder, the pattern is sent verbatim
		l1_d = force1_q ? {l1_hi_q, l1_lo_q} : enc_word_msb;
		l2_d = force2_q ? {l2_hi_q, l2_lo_q} : enc_word_lsb;
		// Fast code wins when both are enabled
		if (fast_en_q)
			det_d = fast_code;
		else if (pwr_en_q)
			det_d = est_bus.estimate;
		else
			det_d = 4'h0;
		rdata_d = 8'h00;
		if (rd)
		begin
			case (addr)
				jlp_pkg::OFS_GATE:
					rdata_d = {6'h00, gate_q};
				jlp_pkg::OFS_FRAME:
					rdata_d = frame_q;
				jlp_pkg::OFS_MFRAME:
					rdata_d = {3'h0, mframe_q};
				jlp_pkg::OFS_DRIVE:
					rdata_d = {4'h0, drive_q};
				jlp_pkg::OFS_FORCE:
					rdata_d = {1'b0, force2_q, 2'h0, force1_q, 3'h0};
				jlp_pkg::OFS_L1_HI:
					rdata_d = l1_hi_q;
				jlp_pkg::OFS_L1_LO:
					rdata_d = {l1_lo_q, 6'h00};
				jlp_pkg::OFS_L2_HI:
					rdata_d = {l2_hi_q, 4'h0};
				jlp_pkg::OFS_L2_LO:
					rdata_d = {l2_lo_q, 2'h0};
				jlp_pkg::OFS_EST:
					rdata_d = {2'h0, pwr_en_q, avg_len_q, 1'b0, fast_en_q};
				jlp_pkg::OFS_STATUS:
					rdata_d = {3'h0, est_bus.busy, est_bus.estimate};
				default:
					rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			rdata_q <= 8'h00;
			oct_q   <= jlp_pkg::RST_FRAME;
			mf_q    <= jlp_pkg::DEF_K_TWO;
			cur_q   <= 4'h0;
			ma_q    <= jlp_pkg::DRV_BASE_MA;
			l1_q    <= 10'h000;
			l2_q    <= 10'h000;
			det_q   <= 4'h0;
		end
		else
		begin
			rdata_q <= rdata_d;
			oct_q   <= oct_d;
			mf_q    <= mf_d;
			cur_q   <= cur_d;
			ma_q    <= ma_d;
			l1_q    <= l1_d;
			l2_q    <= l2_d;
			det_q   <= det_d;
		end
	end

	assign rdata              = rdata_q;
	assign octet_code         = oct_q;
	assign mframe_code        = mf_q;
	assign drive_current_code = cur_q;
	assign drive_current_ma   = ma_q;
	assign lane_one_word      = l1_q;
	assign lane_two_word      = l2_q;
	assign detect             = det_q;
endmodule : jlp_regs
`default_nettype wire

// ---- pkg/jlp_pkg.sv ----
`default_nettype none
package jlp_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_GATE   = 8'ha1;
	localparam logic [7:0] OFS_FRAME  = 8'ha6;
	localparam logic [7:0] OFS_MFRAME = 8'ha7;
	localparam logic [7:0] OFS_DRIVE  = 8'hb0;
	localparam logic [7:0] OFS_FORCE  = 8'hb4;
	localparam logic [7:0] OFS_L1_HI  = 8'hb6;
	localparam logic [7:0] OFS_L1_LO  = 8'hb7;
	localparam logic [7:0] OFS_L2_HI  = 8'hb8;
	localparam logic [7:0] OFS_L2_LO  = 8'hb9;
	localparam logic [7:0] OFS_EST    = 8'hd6;
	localparam logic [7:0] OFS_STATUS = 8'hd7;

	// ****************************************
	// Values after reset and default multiframe sizes
	// ****************************************
	localparam logic [7:0] RST_FRAME  = 8'h01;
	localparam logic [7:0] RST_ZERO8  = 8'h00;
	localparam logic [4:0] DEF_K_ONE  = 5'h10;
	localparam logic [4:0] DEF_K_TWO  = 5'h08;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int GATE_F_BIT  = 0;
	localparam int GATE_K_BIT  = 1;
	localparam int FORCE1_BIT  = 3;
	localparam int FORCE2_BIT  = 6;
	localparam int FAST_EN_BIT = 0;
	localparam int PWR_EN_BIT  = 5;
	localparam int AVG_LSB     = 2;

	// ****************************************
	// Drive current, in mA
	// ****************************************
	localparam logic [5:0] DRV_BASE_MA = 6'h10;
	localparam logic [5:0] DRV_B3_MA   = 6'h10;
	localparam logic [5:0] DRV_B2_MA   = 6'h08;
	localparam logic [5:0] DRV_B1_MA   = 6'h04;
	localparam logic [5:0] DRV_B0_MA   = 6'h02;

	// ****************************************
	// Power estimation
	// ****************************************
	localparam int         AVG_BASE_LOG2 = 10;
	localparam logic [2:0] AVG_MAX_CODE  = 3'h4;
	localparam logic [6:0] EST_OFFSET    = 7'h1c;
	localparam logic [3:0] EST_MAX       = 4'hf;

	typedef enum logic [2:0] {
		JLP_EST_IDLE = 3'b001,
		JLP_EST_ACC  = 3'b010,
		JLP_EST_DONE = 3'b100
	} jlp_est_state_t;
endpackage : jlp_pkg
`default_nettype wire

// ---- pkg/jlp_est_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface jlp_est_if;
	logic        enable;
	logic [2:0]  avg_len;
	logic [11:0] sample;
	logic        sample_valid;
	logic [3:0]  estimate;
	logic        busy;

	modport ctrl (
		output enable,
		output avg_len,
		output sample,
		output sample_valid,
		input  estimate,
		input  busy
	);
	modport est (
		input  enable,
		input  avg_len,
		input  sample,
		input  sample_valid,
		output estimate,
		output busy
	);
endinterface : jlp_est_if
`default_nettype wire

// ---- hdl/jlp_power_est.sv ----
`timescale 1ns/10ps
`default_nettype none
module jlp_power_est (
	input  wire logic clk,
	input  wire logic rst_n,
	jlp_est_if.est    bus
);
	jlp_pkg::jlp_est_state_t st_q, st_d;
	logic [35:0] acc_q, acc_d;
	logic [13:0] cnt_q, cnt_d;
	logic [2:0]  len_q, len_d;
	logic [3:0]  est_q, est_d;
	logic [10:0] mag;
	logic [21:0] sq;
	logic [21:0] avg;
	logic [4:0]  msb;
	logic        nxt;
	logic [6:0]  lvl;
	logic [13:0] last;
	int          sh;

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		st_d  = st_q;
		acc_d = acc_q;
		cnt_d = cnt_q;
		len_d = len_q;
		est_d = est_q;
		// Offset binary: distance from midscale
		mag   = bus.sample[11] ? bus.sample[10:0] : ~bus.sample[10:0];
		sq    = {11'h000, mag} * {11'h000, mag};
		sh    = jlp_pkg::AVG_BASE_LOG2 + int'(len_q);
		last  = 14'((32'd1 << sh) - 32'd1);
		avg   = 22'(acc_q >> sh);
		msb   = 5'h00;
		for (int i = 0; i < 22; i++)
			if (avg[i])
				msb = 5'(i);
		nxt   = (msb != 5'h00) ? avg[msb - 5'h01] : 1'b0;
		// Half-octave steps, close to 1.5 dB; good enough for a level hint
		lvl   = {1'b0, msb, nxt};
		case (st_q)
			jlp_pkg::JLP_EST_IDLE:
			begin
				acc_d = '0;
				cnt_d = '0;
				// Length above 16K clamps, longer windows would overflow
				len_d = (bus.avg_len > jlp_pkg::AVG_MAX_CODE) ? jlp_pkg::AVG_MAX_CODE : bus.avg_len;
				if (bus.enable)
					st_d = jlp_pkg::JLP_EST_ACC;
			end
			jlp_pkg::JLP_EST_ACC:
			begin
				if (!bus.enable)
					st_d = jlp_pkg::JLP_EST_IDLE;
				else if (bus.sample_valid)
				begin
					acc_d = acc_q + 36'(sq);
					cnt_d = cnt_q + 14'h0001;
					if (cnt_q == last)
						st_d = jlp_pkg::JLP_EST_DONE;
				end
			end
			jlp_pkg::JLP_EST_DONE:
			begin
				if (lvl <= jlp_pkg::EST_OFFSET)
					est_d = 4'h0;
				else if (lvl - jlp_pkg::EST_OFFSET > 7'(jlp_pkg::EST_MAX))
					est_d = jlp_pkg::EST_MAX;
				else
					est_d = 4'(lvl - jlp_pkg::EST_OFFSET);
				st_d = jlp_pkg::JLP_EST_IDLE;
			end
			default:
				st_d = jlp_pkg::JLP_EST_IDLE;
		endcase
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q  <= jlp_pkg::JLP_EST_IDLE;
			acc_q <= '0;
			cnt_q <= '0;
			len_q <= '0;
			est_q <= '0;
		end
		else
		begin
			st_q  <= st_d;
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			len_q <= len_d;
			est_q <= est_d;
		end
	end

	assign bus.estimate = est_q;
	assign bus.busy     = (st_q != jlp_pkg::JLP_EST_IDLE);
endmodule : jlp_power_est
`default_nettype wire

// ---- bench/jlp_rx_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module jlp_rx_model (
	input  wire logic       clk,
	input  wire logic [9:0] lane_one_word,
	input  wire logic [9:0] lane_two_word,
	output logic      [9:0] rx_one,
	output logic      [9:0] rx_two
);
	// ********
	// Symbol capture
	// ********
	// Stands in for the deserialiser; no alignment, so forced words show raw
	always_ff @(posedge clk)
	begin
		rx_one <= lane_one_word;
		rx_two <= lane_two_word;
	end
endmodule : jlp_rx_model
`default_nettype wire

// ---- bench/jlp_regs_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module jlp_regs_chk (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic [9:0] enc_word_msb,
	input wire logic [9:0] enc_word_lsb,
	input wire logic [3:0] fast_code,
	input wire logic [7:0] octet_code,
	input wire logic [4:0] mframe_code,
	input wire logic [3:0] drive_current_code,
	input wire logic [5:0] drive_current_ma,
	input wire logic [9:0] lane_one_word,
	input wire logic [9:0] lane_two_word,
	input wire logic [3:0] detect
);
	// ********
	// Shadows of controls
	// ********
	// Outputs only follow inputs from the third edge after reset
	logic [1:0] live_q, live_d;
	logic [7:0] gate_q, gate_d, frc_q, frc_d, est_q, est_d;
	logic       live;
	assign live = live_q == 2'h3;
	always_comb
	begin
		live_d = live ? live_q : live_q + 2'h1;
		gate_d = (wr && addr == jlp_pkg::OFS_GATE) ? wdata : gate_q;
		frc_d = (wr && addr == jlp_pkg::OFS_FORCE) ? wdata : frc_q;
		est_d = (wr && addr == jlp_pkg::OFS_EST) ? wdata : est_q;
	end
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			live_q <= 2'h0;
			gate_q <= 8'h00;
			frc_q <= 8'h00;
			est_q <= 8'h00;
		end
		else
		begin
			live_q <= live_d;
			gate_q <= gate_d;
			frc_q <= frc_d;
			est_q <= est_d;
		end
	end
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_drive;
		live |-> int'(drive_current_ma) == 16 + 16 * drive_current_code[3] - 8 * drive_current_code[2]
			- 4 * drive_current_code[1] - 2 * drive_current_code[0];
	endproperty
	property p_lane_one;
		live && !$past(frc_q[jlp_pkg::FORCE1_BIT]) |-> lane_one_word == $past(enc_word_msb);
	endproperty
	property p_lane_two;
		live && !$past(frc_q[jlp_pkg::FORCE2_BIT]) |-> lane_two_word == $past(enc_word_lsb);
	endproperty
	property p_frame;
		live && !$past(gate_q[jlp_pkg::GATE_F_BIT]) |-> octet_code == 8'h01;
	endproperty
	property p_k16;
		live && !$past(gate_q[jlp_pkg::GATE_K_BIT]) && $stable(octet_code) && octet_code == 8'h00
			|-> mframe_code == jlp_pkg::DEF_K_ONE;
	endproperty
	property p_k8;
		live && !$past(gate_q[jlp_pkg::GATE_K_BIT]) && $stable(octet_code) && octet_code == 8'h01
			|-> mframe_code == jlp_pkg::DEF_K_TWO;
	endproperty
	property p_fast;
		live && $past(est_q[jlp_pkg::FAST_EN_BIT]) |-> detect == $past(fast_code);
	endproperty
	property p_quiet;
		live && !$past(est_q[jlp_pkg::FAST_EN_BIT]) && !$past(est_q[jlp_pkg::PWR_EN_BIT]) |-> detect == 4'h0;
	endproperty
	a_drive: assert property (p_drive) else $error("drive current mismatch");
	a_lane_one: assert property (p_lane_one) else $error("lane one not coder word");
	a_lane_two: assert property (p_lane_two) else $error("lane two not coder word");
	a_frame: assert property (p_frame) else $error("octet code moved without gate");
	a_k16: assert property (p_k16) else $error("default multiframe not 16");
	a_k8: assert property (p_k8) else $error("default multiframe not 8");
	a_fast: assert property (p_fast) else $error("detect not fast code");
	a_quiet: assert property (p_quiet) else $error("detect not zero");
	c_both_forced: cover property (live && frc_q[jlp_pkg::FORCE1_BIT] && frc_q[jlp_pkg::FORCE2_BIT]);
	c_long_mframe: cover property (mframe_code == 5'h16);
	c_full_power: cover property (detect == 4'hf && est_q[jlp_pkg::PWR_EN_BIT]);
endmodule : jlp_regs_chk
bind jlp_regs jlp_regs_chk u_chk (.clk, .reset_n, .addr, .wdata, .wr, .enc_word_msb, .enc_word_lsb,
	.fast_code, .octet_code, .mframe_code, .drive_current_code, .drive_current_ma, .lane_one_word,
	.lane_two_word, .detect);
`default_nettype wire

// ---- bench/jesd_link_param_regs_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module jesd_link_param_regs_tb;
	logic        clk, reset_n, wr, rd, sample_valid;
	logic [7:0]  addr, wdata, rdata, octet_code;
	logic [9:0]  enc_word_msb, enc_word_lsb, lane_one_word, lane_two_word, rx_one, rx_two;
	logic [3:0]  fast_code, drive_current_code, detect;
	logic [11:0] sample;
	logic [4:0]  mframe_code;
	logic [5:0]  drive_current_ma;
	int          n_fail = 0;
	int          total_checks = 0;
	int          i;
	logic [7:0]  zero_ofs [10] = '{jlp_pkg::OFS_GATE, jlp_pkg::OFS_MFRAME, jlp_pkg::OFS_DRIVE,
		jlp_pkg::OFS_FORCE, jlp_pkg::OFS_L1_HI, jlp_pkg::OFS_L1_LO, jlp_pkg::OFS_L2_HI,
		jlp_pkg::OFS_L2_LO, jlp_pkg::OFS_EST, 8'hc0};

	jlp_regs u_dut (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .enc_word_msb, .enc_word_lsb,
		.fast_code, .sample, .sample_valid, .octet_code, .mframe_code, .drive_current_code,
		.drive_current_ma, .lane_one_word, .lane_two_word, .detect);
	jlp_rx_model u_rx (.clk, .lane_one_word, .lane_two_word, .rx_one, .rx_two);

	// ********
	// Clock and moving coder data
	// ********
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Moving data so a stuck lane register cannot pass
	always @(posedge clk)
	begin
		enc_word_msb <= enc_word_msb + 10'h001;
		enc_word_lsb <= enc_word_lsb + 10'h3fd;
		fast_code <= fast_code + 4'h1;
	end

	// ********
	// Bus tasks
	// ********
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// Idle edge, so the next strobe is never set in the same step
		@(posedge clk);
	endtask : wr_reg
	// Derived outputs land one edge after the write edge, so read them one edge later
	task automatic wr_wait(input logic [7:0] a, input logic [7:0] d);
		wr_reg(a, d);
		@(posedge clk);
	endtask : wr_wait
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk(what, 12'(rdata), 12'(exp));
	endtask : rd_chk
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	task automatic wait_det(input logic [3:0] v, input int lo, input int hi);
		int n;
		n = 0;
		// First look one edge on, past a fast code still in flight
		do
		begin
			@(posedge clk);
			n++;
		end
		while (detect !== v && n < hi);
		if (detect !== v)
		begin
			n_fail++;
			$display("ERROR detect expected %h seen %h", v, detect);
		end
		else
			chk("window", 12'(n >= lo), 12'h001);
	endtask : wait_det

	// ********
	// Tests
	// ********
	initial
	begin
		{reset_n, wr, rd, addr, wdata} = '0;
		{enc_word_msb, enc_word_lsb, fast_code} = {10'h155, 10'h0aa, 4'h3};
		sample = 12'hfff;
		sample_valid = 1'b1;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk("octet", 12'(octet_code), 12'h001);
		chk("drive", 12'(drive_current_code), 12'h000);
		chk("drive_ma", 12'(drive_current_ma), 12'h010);
		rd_chk("frame_reg", jlp_pkg::OFS_FRAME, 8'h01);
		for (i = 0; i < 10; i++)
			rd_chk("zero_reg", zero_ofs[i], 8'h00);
		$display("test reset done");
		for (i = 0; i < 16; i++)
		begin
			wr_wait(jlp_pkg::OFS_DRIVE, 8'(i));
			chk("drive_ma", 12'(drive_current_ma), 12'(16 + 16 * i[3] - 8 * i[2] - 4 * i[1] - 2 * i[0]));
			rd_chk("drive_reg", jlp_pkg::OFS_DRIVE, 8'(i));
		end
		$display("test drive done");
		wr_wait(jlp_pkg::OFS_FRAME, 8'h00);
		chk("octet", 12'(octet_code), 12'h001);
		wr_wait(jlp_pkg::OFS_GATE, 8'h01);
		chk("octet", 12'(octet_code), 12'h000);
		chk("mframe", 12'(mframe_code), 12'h010);
		wr_wait(jlp_pkg::OFS_MFRAME, 8'h16);
		chk("mframe", 12'(mframe_code), 12'h010);
		wr_wait(jlp_pkg::OFS_GATE, 8'h03);
		chk("mframe", 12'(mframe_code), 12'h016);
		wr_wait(jlp_pkg::OFS_GATE, 8'h00);
		chk("mframe", 12'(mframe_code), 12'h008);
		$display("test framing done");
		wr_reg(jlp_pkg::OFS_L1_HI, 8'ha5);
		wr_reg(jlp_pkg::OFS_L1_LO, 8'hc0);
		wr_reg(jlp_pkg::OFS_L2_HI, 8'h9f);
		wr_reg(jlp_pkg::OFS_L2_LO, 8'hb7);
		wr_wait(jlp_pkg::OFS_FORCE, 8'h08);
		@(posedge clk);
		chk("rx_one", 12'(rx_one), 12'h297);
		wr_wait(jlp_pkg::OFS_FORCE, 8'h48);
		@(posedge clk);
		chk("rx_one", 12'(rx_one), 12'h297);
		chk("rx_two", 12'(rx_two), 12'h26d);
		wr_wait(jlp_pkg::OFS_FORCE, 8'h00);
		$display("test lanes done");
		// Both enables, then fast only, which aborts that window
		wr_wait(jlp_pkg::OFS_EST, 8'h21);
		wr_wait(jlp_pkg::OFS_EST, 8'h01);
		wr_reg(jlp_pkg::OFS_EST, 8'h20);
		wait_det(4'hf, 1024, 1100);
		wr_wait(jlp_pkg::OFS_EST, 8'h00);
		chk("detect", 12'(detect), 12'h000);
		sample <= 12'ha00;
		wr_reg(jlp_pkg::OFS_EST, 8'h24);
		wait_det(4'h8, 2048, 2200);
		rd_chk("status", jlp_pkg::OFS_STATUS, 8'h18);
		$display("test estimate done");
		complete_run();
	end
endmodule : jesd_link_param_regs_tb
`default_nettype wire
